// ### hdl/eeprom_access_control.sv
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "eeprom_access_params.svh"

// Contract
// - Control bits 7 and 6 always read zero and do nothing.
// - Mode 00 atomic 3.4 ms, 01 erase 1.8 ms, 10 write 1.8 ms, 11 reserved.
// - Mode field writes are ignored while programming is busy.
// - Reset clears the mode field unless programming is in progress.
// - Ready interrupt follows enable bit, global enable and not busy.
// - Programming starts only if enabled within four cycles of master enable.
// - Hardware clears master enable four cycles after it was set.
// - Program enable with master enable clear does nothing.
// - Accepted start runs the current mode on the addressed byte with data.
// - Starting programming stalls the CPU for two cycles.
// - Busy flag stays set for the programming time, then clears.
// - Flash, fuse and lock programming is blocked while busy.
// - Read strobe loads the addressed byte into the data register two cycles later.
// - A read strobe stalls the CPU for four cycles.
// - While busy, read strobes and address writes are refused.
// - Eight-bit scratch register, free read and write, reset to zero.
// - Address register selects one of 256 bytes.
// - Data register feeds writes and receives read bytes.
// - A started programming job completes even through a chip reset.
module eeprom_access_control #(
    parameter int ADDR_W = 8,
    parameter int TIMER_W = 18,
    parameter int ATOMIC_CYCLES = `ATOMIC_CYCLES,
    parameter int SPLIT_CYCLES = `SPLIT_CYCLES
) (
    // Clock and resets
    input wire logic clk,
    input wire logic resetn,
    input wire logic poweronResetn,
    // AXI4-Lite write address and data
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // System side
    output logic cpuStall,
    output logic readyIrq,
    output logic nvmProgramLockout
);

    import eeprom_access_pkg::*;

    // ----------------------------------------
    // Parameter checks
    // ----------------------------------------
    generate
        if (ADDR_W < 8 || ADDR_W > 32) begin : bad_addr_w
            $error("ADDR_W must be 8 to 32");
        end
        if (ATOMIC_CYCLES < 4 || ATOMIC_CYCLES >= (1 << TIMER_W) ||
            SPLIT_CYCLES < 4 || SPLIT_CYCLES >= (1 << TIMER_W)) begin : bad_timer
            $error("Programming cycle counts do not fit TIMER_W");
        end
    endgenerate

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    // Register index from a byte address
    function automatic logic [5:0] regIndex(input logic [ADDR_W-1:0] addr);
        return addr[7:2];
    endfunction

    // Whether an address hits a register
    function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
        logic [5:0] idx;
        idx = regIndex(addr);
        return ((addr >> 8) == '0) &&
               (idx == `IDX_GP_SCRATCH_ONE || idx == `IDX_EEPROM_CONTROL ||
                idx == `IDX_BYTE_DATA || idx == `IDX_BYTE_ADDRESS || idx == `IDX_CPU_STATUS_WORD);
    endfunction

    // Programming time for a mode
    function automatic logic [TIMER_W-1:0] progCycles(input logic [1:0] mode);
        return (mode == `MODE_ATOMIC) ? TIMER_W'(ATOMIC_CYCLES) : TIMER_W'(SPLIT_CYCLES);
    endfunction

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    ctrl_t ctrl;
    prog_job_t job;
    eng_state_t engState;
    logic [7:0] gpScratchOne;
    logic [7:0] byteData;
    logic [7:0] byteAddress;
    logic globalIrqEnable;
    logic [2:0] masterCnt;
    logic [2:0] stallCnt;
    logic [TIMER_W-1:0] progTimer;
    logic [7:0] oldByte;
    logic [1:0] chipRstPipe;
    logic awHeld;
    logic wHeld;
    logic wrApplied;
    logic [ADDR_W-1:0] awAddrQ;
    logic [31:0] wDataQ;
    logic [3:0] wStrbQ;
    logic readCapture;
    logic [7:0] memRdData;

    // ----------------------------------------
    // Write channel decode
    // ----------------------------------------
    wire awFire = awvalid && awready;
    wire wFire = wvalid && wready;
    wire awGot = awHeld || awFire;
    wire wGot = wHeld || wFire;
    wire doWrite = awGot && wGot && !wrApplied;
    wire [ADDR_W-1:0] wrAddr = awHeld ? awAddrQ : awaddr;
    wire [31:0] wrData = wHeld ? wDataQ : wdata;
    wire [3:0] wrStrb = wHeld ? wStrbQ : wstrb;
    wire wrMapped = isMapped(wrAddr);
    wire wrLane = doWrite && wrMapped && wrStrb[0];
    wire [5:0] wrIdx = regIndex(wrAddr);
    wire [7:0] wrByte = wrData[7:0];

    // Per-register write strobes
    wire ctlWrite = wrLane && (wrIdx == `IDX_EEPROM_CONTROL);
    wire scratchWrite = wrLane && (wrIdx == `IDX_GP_SCRATCH_ONE);
    wire dataWrite = wrLane && (wrIdx == `IDX_BYTE_DATA);
    wire addrWrite = wrLane && (wrIdx == `IDX_BYTE_ADDRESS);
    wire statusWrite = wrLane && (wrIdx == `IDX_CPU_STATUS_WORD);

    // ----------------------------------------
    // Control decisions
    // ----------------------------------------
    wire busy = (engState != ENG_IDLE);
    wire chipInReset = !chipRstPipe[1];
    wire masterProgEnable = (masterCnt != 3'h0);
    wire progGo = ctlWrite && wrByte[`CTL_PROG_ENABLE_BUSY] && masterProgEnable && !busy;
    wire readGo = ctlWrite && wrByte[`CTL_READ_STROBE] && !busy && !progGo;
    wire masterSet = ctlWrite && wrByte[`CTL_MASTER_PROG_ENABLE];
    wire memRdEn = readGo || (engState == ENG_FETCH);
    wire [7:0] memRdAddr = (engState == ENG_FETCH) ? job.addr : byteAddress;
    wire memWrEn = (engState == ENG_COMMIT) && (job.mode != `MODE_RESERVED);
    wire timerDone = (progTimer == '0);

    // Byte to commit for each mode
    wire [7:0] commitByte = (job.mode == `MODE_ERASE_ONLY) ? `ERASED_BYTE :
                            (job.mode == `MODE_WRITE_ONLY) ? (oldByte & job.data) : job.data;

    // Control register read image, top bits zero
    wire [7:0] ctlImage = {2'b00, ctrl.progModeField, ctrl.readyIrqEnable,
                           masterProgEnable, busy, 1'b0};

    // ----------------------------------------
    // Byte store
    // ----------------------------------------
    eeprom_byte_store #(
        .ADDR_W(8),
        .DATA_W(8)
    ) u_store (
        .clk(clk),
        .rdEn(memRdEn),
        .rdAddr(memRdAddr),
        .rdData(memRdData),
        .wrEn(memWrEn),
        .wrAddr(job.addr),
        .wrData(commitByte)
    );

    // ----------------------------------------
    // Chip reset seen by the engine domain
    // ----------------------------------------
    // Two stages, only the second is read
    always_ff @(posedge clk or negedge poweronResetn) begin
        if (!poweronResetn) begin
            chipRstPipe <= 2'b00;
        end else begin
            chipRstPipe <= {chipRstPipe[0], resetn};
        end
    end

    // ----------------------------------------
    // Programming engine (power-on reset only)
    // ----------------------------------------
    // Engine keeps running through chip reset
    always_ff @(posedge clk or negedge poweronResetn) begin
        if (!poweronResetn) begin
            engState <= ENG_IDLE;
        end else begin
            case (engState)
                ENG_IDLE: begin
                    if (progGo) begin
                        engState <= ENG_FETCH;
                    end
                end
                ENG_FETCH: begin
                    engState <= (job.mode == `MODE_RESERVED) ? ENG_IDLE : ENG_PROGRAM;
                end
                ENG_PROGRAM: begin
                    if (timerDone) begin
                        engState <= ENG_COMMIT;
                    end
                end
                ENG_COMMIT: begin
                    engState <= ENG_IDLE;
                end
                default: begin
                    engState <= ENG_IDLE;
                end
            endcase
        end
    end

    // Job latch and programming timer
    always_ff @(posedge clk or negedge poweronResetn) begin
        if (!poweronResetn) begin
            job <= '0;
            progTimer <= '0;
        end else if (progGo) begin
            job <= '{mode: ctrl.progModeField, addr: byteAddress, data: byteData};
            progTimer <= progCycles(ctrl.progModeField) - TIMER_W'(3);
        end else if (engState == ENG_PROGRAM && !timerDone) begin
            progTimer <= progTimer - TIMER_W'(1);
        end
    end

    // Old contents for write-only merge
    always_ff @(posedge clk or negedge poweronResetn) begin
        if (!poweronResetn) begin
            oldByte <= `RESET_BYTE;
        end else if (engState == ENG_PROGRAM && progTimer == progCycles(job.mode) - TIMER_W'(3)) begin
            oldByte <= memRdData;
        end
    end

    // Mode field: kept over chip reset while busy
    always_ff @(posedge clk or negedge poweronResetn) begin
        if (!poweronResetn) begin
            ctrl.progModeField <= `MODE_ATOMIC;
        end else if (chipInReset) begin
            if (!busy) begin
                ctrl.progModeField <= `MODE_ATOMIC;
            end
        end else if (ctlWrite && !busy) begin
            ctrl.progModeField <= wrByte[`CTL_PROG_MODE_HI:`CTL_PROG_MODE_LO];
        end
    end

    // ----------------------------------------
    // Software registers
    // ----------------------------------------
    // Interrupt enables
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl.readyIrqEnable <= 1'b0;
            globalIrqEnable <= 1'b0;
        end else begin
            if (ctlWrite) begin
                ctrl.readyIrqEnable <= wrByte[`CTL_READY_IRQ_ENABLE];
            end
            if (statusWrite) begin
                globalIrqEnable <= wrByte[`STATUS_GLOBAL_IRQ];
            end
        end
    end

    // Master enable window
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            masterCnt <= 3'h0;
        end else if (masterSet) begin
            masterCnt <= `MASTER_WINDOW_CYCLES;
        end else if (masterProgEnable) begin
            masterCnt <= masterCnt - 3'h1;
        end
    end

    // Scratch, address and data registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            gpScratchOne <= `RESET_BYTE;
            byteAddress <= `RESET_BYTE;
            byteData <= `RESET_BYTE;
            readCapture <= 1'b0;
        end else begin
            readCapture <= readGo;
            if (scratchWrite) begin
                gpScratchOne <= wrByte;
            end
            if (addrWrite && !busy) begin
                byteAddress <= wrByte;
            end
            if (readCapture) begin
                byteData <= memRdData;
            end else if (dataWrite) begin
                byteData <= wrByte;
            end
        end
    end

    // CPU stall counter
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stallCnt <= 3'h0;
        end else if (progGo) begin
            stallCnt <= `PROG_STALL_CYCLES;
        end else if (readGo) begin
            stallCnt <= `READ_STALL_CYCLES;
        end else if (stallCnt != 3'h0) begin
            stallCnt <= stallCnt - 3'h1;
        end
    end

    // ----------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------
    assign awready = !awHeld && !wrApplied;
    assign wready = !wHeld && !wrApplied;

    // Hold whichever half arrives first
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddrQ <= '0;
            wDataQ <= 32'h00000000;
            wStrbQ <= 4'h0;
        end else if (doWrite) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
        end else begin
            if (awFire) begin
                awHeld <= 1'b1;
                awAddrQ <= awaddr;
            end
            if (wFire) begin
                wHeld <= 1'b1;
                wDataQ <= wdata;
                wStrbQ <= wstrb;
            end
        end
    end

    // Response waits out the CPU stall
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wrApplied <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
        end else if (doWrite) begin
            wrApplied <= 1'b1;
            bresp <= wrMapped ? `RESP_OKAY : `RESP_SLVERR;
        end else if (bvalid && bready) begin
            bvalid <= 1'b0;
            wrApplied <= 1'b0;
        end else if (wrApplied && stallCnt == 3'h0) begin
            bvalid <= 1'b1;
        end
    end

    // ----------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------
    assign arready = !rvalid;
    wire [5:0] rdIdx = regIndex(araddr);

    // Read data mux
    wire [7:0] rdByte = (rdIdx == `IDX_GP_SCRATCH_ONE) ? gpScratchOne :
                        (rdIdx == `IDX_EEPROM_CONTROL) ? ctlImage :
                        (rdIdx == `IDX_BYTE_DATA) ? byteData :
                        (rdIdx == `IDX_BYTE_ADDRESS) ? byteAddress :
                        {globalIrqEnable, 7'h00};

    // Registered read answer
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= `RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= isMapped(araddr) ? {24'h000000, rdByte} : 32'h00000000;
            rresp <= isMapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // System side outputs
    // ----------------------------------------
    assign cpuStall = (stallCnt != 3'h0);
    assign readyIrq = ctrl.readyIrqEnable && globalIrqEnable && !busy;
    assign nvmProgramLockout = busy;

endmodule // eeprom_access_control

// ### include/eeprom_access_params.svh
`ifndef EEPROM_ACCESS_PARAMS_SVH
`define EEPROM_ACCESS_PARAMS_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define IDX_GP_SCRATCH_ONE 6'h15
`define IDX_EEPROM_CONTROL 6'h1C
`define IDX_BYTE_DATA 6'h1D
`define IDX_BYTE_ADDRESS 6'h1E
`define IDX_CPU_STATUS_WORD 6'h3F

// ----------------------------------------
// Control and status register field positions
// ----------------------------------------
`define CTL_READ_STROBE 0
`define CTL_PROG_ENABLE_BUSY 1
`define CTL_MASTER_PROG_ENABLE 2
`define CTL_READY_IRQ_ENABLE 3
`define CTL_PROG_MODE_LO 4
`define CTL_PROG_MODE_HI 5
`define STATUS_GLOBAL_IRQ 7

// ----------------------------------------
// Programming mode codes and reset values
// ----------------------------------------
`define MODE_ATOMIC 2'h0
`define MODE_ERASE_ONLY 2'h1
`define MODE_WRITE_ONLY 2'h2
`define MODE_RESERVED 2'h3
`define RESET_BYTE 8'h00
`define ERASED_BYTE 8'hFF

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 20
`define ATOMIC_TIME_US 3400
`define SPLIT_TIME_US 1800
`define ATOMIC_CYCLES ((`ATOMIC_TIME_US * 1000) / `CLK_PERIOD_NS)
`define SPLIT_CYCLES ((`SPLIT_TIME_US * 1000) / `CLK_PERIOD_NS)
`define MASTER_WINDOW_CYCLES 3'h4
`define PROG_STALL_CYCLES 3'h2
`define READ_STALL_CYCLES 3'h4

// ----------------------------------------
// AXI responses
// ----------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### include/eeprom_access_pkg.sv
package eeprom_access_pkg;

    // Software-visible control fields
    typedef struct packed {
        logic [1:0] progModeField;
        logic readyIrqEnable;
    } ctrl_t;

    // One latched programming job
    typedef struct packed {
        logic [1:0] mode;
        logic [7:0] addr;
        logic [7:0] data;
    } prog_job_t;

    // Programming engine states
    typedef enum logic [1:0] {
        ENG_IDLE,
        ENG_FETCH,
        ENG_PROGRAM,
        ENG_COMMIT
    } eng_state_t;

endpackage

// ### hdl/eeprom_byte_store.sv
`timescale 1ns/100ps

module eeprom_byte_store #(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 8
) (
    // Clock
    input wire logic clk,
    // Read port
    input wire logic rdEn,
    input wire logic [ADDR_W-1:0] rdAddr,
    output logic [DATA_W-1:0] rdData,
    // Write port
    input wire logic wrEn,
    input wire logic [ADDR_W-1:0] wrAddr,
    input wire logic [DATA_W-1:0] wrData
);

    logic [DATA_W-1:0] cells [0:(1<<ADDR_W)-1];

    // Array write, registered read
    always_ff @(posedge clk) begin
        if (wrEn) begin
            cells[wrAddr] <= wrData;
        end
        if (rdEn) begin
            rdData <= cells[rdAddr];
        end
    end

endmodule // eeprom_byte_store

// ### bench/eeprom_access_control_chk.sv
`timescale 1ns/100ps

// ----------------------------------------
// Port checker
// ----------------------------------------
module eeprom_access_control_chk #(
    parameter int ATOMIC_CYCLES = 170000
) (
    // Clock and resets
    input wire logic clk, resetn, poweronResetn,
    // Register bus
    input wire logic [7:0] awaddr, araddr,
    input wire logic [31:0] wdata, rdata,
    input wire logic awvalid, awready, wvalid, wready, arvalid, arready, rvalid,
    // System side
    input wire logic cpuStall, readyIrq, nvmProgramLockout
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn || !poweronResetn);

    logic [3:0] masterAge;
    logic [7:0] lastAr;
    logic [19:0] busyLen;
    wire masterSet = awvalid && awready && wvalid && wready && awaddr == 8'h70 && wdata[2];

    // Cycles since master enable, saturating
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) masterAge <= 4'hF;
        else if (masterSet) masterAge <= 4'h0;
        else if (masterAge != 4'hF) masterAge <= masterAge + 4'h1;
    end

    // Address of the last accepted read
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) lastAr <= 8'h00;
        else if (arvalid && arready) lastAr <= araddr;
    end

    // Length of the current busy span
    always_ff @(posedge clk or negedge poweronResetn) begin
        if (!poweronResetn) busyLen <= 20'h0;
        else busyLen <= nvmProgramLockout ? busyLen + 20'h1 : 20'h0;
    end

    AST_IRQ_QUIET_BUSY: assert property (nvmProgramLockout |-> !readyIrq)
        else $error("ready irq while busy");
    AST_CTRL_TOP_ZERO: assert property (rvalid && lastAr == 8'h70 |-> rdata[7:6] == 2'h0)
        else $error("control top bits not zero");
    AST_STALL_LEN: assert property ($rose(cpuStall) |->
        cpuStall[*2] ##1 (!cpuStall or (cpuStall[*2] ##1 !cpuStall)))
        else $error("bad stall length");
    AST_START_IN_WINDOW: assert property ($rose(nvmProgramLockout) |-> masterAge inside {[1:4]})
        else $error("start outside master window");
    AST_WINDOW_CLOSES: assert property (rvalid && lastAr == 8'h70 && rdata[2] |-> masterAge <= 4'h5)
        else $error("master enable still open too late");
    AST_BUSY_BOUND: assert property (nvmProgramLockout |-> busyLen <= ATOMIC_CYCLES + 1)
        else $error("busy too long");
    AST_NO_READ_WHILE_BUSY: assert property (nvmProgramLockout && $past(nvmProgramLockout) |->
        !$rose(cpuStall))
        else $error("stall started while busy");
    AST_BUSY_VISIBLE: assert property (arvalid && arready && araddr == 8'h70 |=>
        rdata[1] == $past(nvmProgramLockout))
        else $error("busy bit differs from lockout");
endmodule // eeprom_access_control_chk

bind eeprom_access_control eeprom_access_control_chk #(.ATOMIC_CYCLES(ATOMIC_CYCLES)) i_eeprom_access_control_chk (
    .clk, .resetn, .poweronResetn, .awaddr, .araddr, .wdata, .rdata, .awvalid, .awready, .wvalid, .wready,
    .arvalid, .arready, .rvalid, .cpuStall, .readyIrq, .nvmProgramLockout);

// ### bench/cpu_bus_model.sv
`timescale 1ns/100ps

// ----------------------------------------
// CPU side bus master and firmware routines
// ----------------------------------------
module cpu_bus_model (
    // Clock
    input wire logic clk,
    // Master outputs
    output logic [7:0] awaddr, araddr,
    output logic [31:0] wdata,
    output logic awvalid, wvalid, bready, arvalid, rready,
    // Slave answers
    input wire logic awready, wready, bvalid, arready, rvalid,
    input wire logic [1:0] bresp,
    input wire logic [31:0] rdata
);
    logic [1:0] lastResp;
    logic [31:0] rv;

    // Idle bus at time zero
    initial begin
        {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    end

    // Single write; released lines show inverted values
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        awaddr <= a; wdata <= {24'h000000, d}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) begin awvalid <= 1'b0; awaddr <= ~a; end
            if (wvalid && wready) begin wvalid <= 1'b0; wdata <= ~wdata; end
        end while (!bvalid);
        bready <= 1'b0;
        lastResp = bresp;
    endtask

    // Single read
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) begin arvalid <= 1'b0; araddr <= ~a; end
        end while (!rvalid);
        rready <= 1'b0;
        rv = rdata;
    endtask

    // Poll until the busy flag clears
    task automatic waitIdle;
        do rd(8'h70); while (rv[1] !== 1'b0);
    endtask

    // Firmware read of one byte
    task automatic readByte(input logic [7:0] a);
        waitIdle();
        wr(8'h78, a);
        wr(8'h70, 8'h01);
        rd(8'h74);
    endtask

    // Firmware programming with a gap after the master enable
    task automatic progByte(input logic [1:0] m, input logic [7:0] a, input logic [7:0] d, input int gap);
        waitIdle();
        wr(8'h70, {2'h0, m, 4'h0});
        wr(8'h78, a);
        wr(8'h74, d);
        wr(8'h70, {2'h0, m, 4'h4});
        repeat (gap) @(posedge clk);
        wr(8'h70, {2'h0, m, 4'h2});
    endtask
endmodule // cpu_bus_model

// ### bench/test_eeprom_access_control.sv
`timescale 1ns/100ps

module test_eeprom_access_control;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic poweronResetn = 1'b0;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic cpuStall, readyIrq, nvmProgramLockout;
    logic [7:0] em [256];
    logic [7:0] a, d, v;
    logic [1:0] modes [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h2};
    logic [2:0] prot = 3'h0;
    logic [3:0] wstrb = 4'hF;
    int seed = 2;
    int miscompares = 0;
    int num_checks = 0;

    // ----------------------------------------
    // Clock and instances
    // ----------------------------------------
    always #10 clk = ~clk;

    eeprom_access_control #(.ATOMIC_CYCLES(40), .SPLIT_CYCLES(20)) i_eeprom_access_control (
        .clk, .resetn, .poweronResetn, .awaddr, .awprot(prot), .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arprot(prot), .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .cpuStall, .readyIrq, .nvmProgramLockout);

    cpu_bus_model i_cpu_bus_model (
        .clk, .awaddr, .araddr, .wdata, .awvalid, .wvalid, .bready, .arvalid, .rready, .awready, .wready,
        .bvalid, .arready, .rvalid, .bresp, .rdata);

    // ----------------------------------------
    // Expectations and reporting
    // ----------------------------------------
    function automatic logic [7:0] progResult(input logic [1:0] m, input logic [7:0] old, input logic [7:0] nd);
        case (m)
            2'h0: return nd;
            2'h1: return 8'hFF;
            2'h2: return old & nd;
            default: return old;
        endcase
    endfunction

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            miscompares++;
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic rdChk(input logic [7:0] addr, input string what, input logic [7:0] exp);
        i_cpu_bus_model.rd(addr);
        chk(what, exp, i_cpu_bus_model.rv[7:0]);
    endtask

    task automatic wr(input logic [7:0] addr, input logic [7:0] dat);
        i_cpu_bus_model.wr(addr, dat);
    endtask

    task automatic pulseReset;
        @(posedge clk);
        resetn <= 1'b0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
    endtask

    // Watchdog against hangs
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        tally_and_finish();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        poweronResetn <= 1'b1;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        rdChk(8'h54, "scratch reset", 8'h00);
        rdChk(8'h70, "control reset", 8'h00);
        for (int i = 0; i < 4; i++) begin
            v = 8'($random(seed));
            prot <= 3'($random(seed));
            wr(8'h54, v);
            wr(8'h40, ~v);
            chk("unmapped resp", 8'h02, {6'h00, i_cpu_bus_model.lastResp});
            rdChk(8'h54, "scratch", v);
        end
        wstrb <= 4'h0;
        wr(8'h54, ~v);
        wstrb <= 4'hF;
        rdChk(8'h54, "strobe off", v);
        $display("test registers done");

        for (int j = 0; j < 2; j++) begin
            a = 8'($random(seed));
            foreach (modes[k]) begin
                d = 8'($random(seed));
                i_cpu_bus_model.progByte(modes[k], a, d, 0);
                @(negedge clk);
                if (modes[k] != 2'h3) chk("lockout", 8'h01, {7'h00, nvmProgramLockout});
                em[a] = progResult(modes[k], em[a], d);
                i_cpu_bus_model.readByte(a);
                chk("program result", em[a], i_cpu_bus_model.rv[7:0]);
            end
        end
        $display("test program modes done");

        d = 8'($random(seed));
        i_cpu_bus_model.progByte(2'h0, a, d, 0);
        wr(8'h70, 8'h30);
        wr(8'h78, ~a);
        wr(8'h70, 8'h01);
        rdChk(8'h70, "control busy", 8'h02);
        i_cpu_bus_model.waitIdle();
        rdChk(8'h78, "address kept", a);
        em[a] = d;
        $display("test busy refusals done");

        wr(8'h70, 8'h02);
        rdChk(8'h70, "no master start", 8'h00);
        i_cpu_bus_model.progByte(2'h0, a, ~d, 6);
        i_cpu_bus_model.readByte(a);
        chk("late start", em[a], i_cpu_bus_model.rv[7:0]);
        $display("test master window done");

        wr(8'hFC, 8'h80);
        wr(8'h70, 8'h08);
        @(negedge clk);
        chk("irq on", 8'h01, {7'h00, readyIrq});
        wr(8'h70, 8'h00);
        @(negedge clk);
        chk("irq off", 8'h00, {7'h00, readyIrq});
        $display("test interrupt done");

        d = 8'($random(seed));
        i_cpu_bus_model.progByte(2'h2, a, d, 0);
        pulseReset();
        @(negedge clk);
        chk("lockout in reset", 8'h01, {7'h00, nvmProgramLockout});
        rdChk(8'h70, "mode kept", 8'h22);
        i_cpu_bus_model.readByte(a);
        chk("reset program", progResult(2'h2, em[a], d), i_cpu_bus_model.rv[7:0]);
        pulseReset();
        rdChk(8'h70, "mode cleared", 8'h00);
        $display("test reset done");
        tally_and_finish();
    end
endmodule // test_eeprom_access_control
